//--- design/lpmr_defines.svh
// Constants of the pin mode and reset block: register indices, reset
// values, selector codes and the blink timing base.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LPMR_DEFINES_SVH
`define LPMR_DEFINES_SVH

// Register pointer indices.
`define LPMR_IDX_LEVEL_LO 4'h0
`define LPMR_IDX_LEVEL_HI 4'h1
`define LPMR_IDX_PSC_A 4'h2
`define LPMR_IDX_DUTY_A 4'h3
`define LPMR_IDX_PSC_B 4'h4
`define LPMR_IDX_DUTY_B 4'h5
`define LPMR_IDX_SEL0 4'h6
`define LPMR_IDX_LAST 4'h9
`define LPMR_PTR_WRAP 4'h0

// Command byte layout.
`define LPMR_CMD_AI_BIT 4
`define LPMR_CMD_PTR_MSB 3

// Reset values.
`define LPMR_PSC_RESET 8'hff
`define LPMR_DUTY_RESET 8'h80
`define LPMR_SEL_RESET 8'h55
`define LPMR_BYTE_ZERO 8'h00

// Selector codes.
`define LPMR_SEL_LOW 2'h0
`define LPMR_SEL_RELEASE 2'h1
`define LPMR_SEL_WAVE_A 2'h2
`define LPMR_SEL_WAVE_B 2'h3

// Blink timing: 256 counter steps make one period of (psc+1)/44 s.
`define LPMR_CLK_HZ 250000000
`define LPMR_BLINK_BASE_HZ 44
`define LPMR_STEPS_PER_PERIOD 256
`define LPMR_TICK_DIV \
    (`LPMR_CLK_HZ / (`LPMR_BLINK_BASE_HZ * `LPMR_STEPS_PER_PERIOD))

`endif

//--- design/lpmr_pkg.sv
// Types shared by the pin mode and reset block.
// Assumes the defines header sits beside it.
`default_nettype none
`include "lpmr_defines.svh"

package lpmr_pkg;
    typedef logic [7:0] lpmr_byte_t;
    typedef logic [3:0] lpmr_ptr_t;
    typedef logic [1:0] lpmr_sel_t;
endpackage : lpmr_pkg

`default_nettype wire

//--- design/lpmr_blink_if.sv
// Link between the register file and one blink waveform generator.
// Assumes both ends run on the same clock.
`default_nettype none

interface lpmr_blink_if;
    import lpmr_pkg::*;
    lpmr_byte_t psc;
    lpmr_byte_t duty;
    logic restart;
    logic wave_low;
    modport cfg (output psc, output duty, output restart, input wave_low);
    modport gen (input psc, input duty, input restart, output wave_low);
endinterface : lpmr_blink_if

`default_nettype wire

//--- design/lpmr_blink.sv
// One blink waveform generator: a base tick divider, a prescaler and an
// 8-bit step counter compared against the duty setting.
// Assumes run is the synchronised internal reset release.
`default_nettype none
`include "lpmr_defines.svh"

module lpmr_blink
    import lpmr_pkg::*;
#(
    parameter int TICK_DIV = `LPMR_TICK_DIV
) (
    // Clock and internal reset.
    input wire logic mclk,
    input wire logic run,
    // Settings in, waveform out.
    lpmr_blink_if.gen bi
);
    localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

    logic [TW-1:0] tick_cnt;
    lpmr_byte_t pre_cnt;
    lpmr_byte_t step;

    wire tick_end = (tick_cnt == TICK_LAST);
    wire pre_end = (pre_cnt == bi.psc);

    // Base tick and prescaler; a duty write restarts the period at zero.
    always_ff @(posedge mclk) begin
        if (!run || bi.restart) begin
            tick_cnt <= '0;
            pre_cnt <= `LPMR_BYTE_ZERO;
            step <= `LPMR_BYTE_ZERO;
        end else if (tick_end) begin
            tick_cnt <= '0;
            pre_cnt <= pre_end ? `LPMR_BYTE_ZERO : pre_cnt + 8'h01;
            if (pre_end) begin
                step <= step + 8'h01;
            end
        end else begin
            tick_cnt <= tick_cnt + TW'(1);
        end
    end

    // Pin is pulled low while the step count is below the duty value.
    always_ff @(posedge mclk) begin
        if (!run) begin
            bi.wave_low <= 1'b0;
        end else begin
            bi.wave_low <= (step < bi.duty);
        end
    end
endmodule : lpmr_blink

`default_nettype wire

//--- design/lpmr_top.sv
// Pin mode and reset block of a 16-pin open-drain LED and GPIO expander:
// register file reached through a byte port, pin selectors, pin level
// capture and reset handling.
// Assumes the serial-bus slave in front of it delivers whole command and
// data bytes on mclk, and that the pins have external pull-ups.
//
// Functional notes
// - Unused LED pins serve as GPIO.
// - Code 01 releases the pin.
// - Code 00 drives the pin low.
// - Codes 10 and 11 follow waves a, b.
// - External reset low restores all defaults.
// - Defaults held while external reset low.
// - Power-on reset holds defaults until release.
// - Four selector registers, pin 0 lowest.
// - Step counter below duty gives low.
// - Level registers show pins, ignore writes.
// - Auto-increment pointer wraps after last register.
`default_nettype none
`include "lpmr_defines.svh"

module lpmr_top
    import lpmr_pkg::*;
#(
    parameter int PINS = 16,
    parameter int TICK_DIV = `LPMR_TICK_DIV
) (
    // Clock, external reset and power-on reset indication.
    input wire logic mclk,
    input wire logic rstn,
    input wire logic por_n,
    // Byte port from the serial-bus slave.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Status.
    output logic [3:0] reg_ptr,
    output logic auto_increment_flag,
    output logic in_reset,
    // Open-drain driver pins.
    input wire logic [PINS-1:0] driver_pins_in,
    output logic [PINS-1:0] driver_pins_out,
    output logic [PINS-1:0] driver_pins_oe
);
    localparam int NSEL = PINS / 4;

    // Pointer step with wrap after the last register.
    function automatic lpmr_ptr_t ptr_step(input lpmr_ptr_t p);
        ptr_step = (p >= `LPMR_IDX_LAST) ? `LPMR_PTR_WRAP : p + 4'h1;
    endfunction : ptr_step

    // Two-stage reset release; either reset clears run on the next edge, and defaults load one edge later.
    logic rst_meta;
    logic run;
    always_ff @(posedge mclk) begin
        if (!rstn || !por_n) begin
            rst_meta <= 1'b0;
            run <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            run <= rst_meta;
        end
    end
    assign in_reset = !run;

    // Pin input synchroniser; only the second stage is used downstream.
    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    always_ff @(posedge mclk) begin
        pin_meta <= driver_pins_in;
        pin_sync <= pin_meta;
    end

    // Settings registers.
    lpmr_byte_t psc_a;
    lpmr_byte_t psc_b;
    lpmr_byte_t duty_a;
    lpmr_byte_t duty_b;
    lpmr_byte_t pin_selector_reg [NSEL];
    lpmr_ptr_t ptr;
    logic ai;

    // Write decode as named wires.
    wire wr_psc_a = wr_valid && (ptr == `LPMR_IDX_PSC_A);
    wire wr_duty_a = wr_valid && (ptr == `LPMR_IDX_DUTY_A);
    wire wr_psc_b = wr_valid && (ptr == `LPMR_IDX_PSC_B);
    wire wr_duty_b = wr_valid && (ptr == `LPMR_IDX_DUTY_B);
    wire ptr_in_sel = (ptr >= `LPMR_IDX_SEL0) && (ptr <= `LPMR_IDX_LAST);
    wire [3:0] sel_idx = ptr - `LPMR_IDX_SEL0;
    wire advance = ai && (wr_valid || rd_req);

    // Command byte loads the pointer; data bytes advance it when enabled.
    always_ff @(posedge mclk) begin
        if (!run) begin
            ptr <= `LPMR_PTR_WRAP;
            ai <= 1'b0;
        end else if (cmd_valid) begin
            ptr <= cmd_byte[`LPMR_CMD_PTR_MSB:0];
            ai <= cmd_byte[`LPMR_CMD_AI_BIT];
        end else if (advance) begin
            ptr <= ptr_step(ptr);
        end
    end
    assign reg_ptr = ptr;
    assign auto_increment_flag = ai;

    // Blink settings; writes to the level registers fall through unused.
    always_ff @(posedge mclk) begin
        if (!run) begin
            psc_a <= `LPMR_PSC_RESET;
            psc_b <= `LPMR_PSC_RESET;
            duty_a <= `LPMR_DUTY_RESET;
            duty_b <= `LPMR_DUTY_RESET;
        end else begin
            if (wr_psc_a) psc_a <= wr_data;
            if (wr_duty_a) duty_a <= wr_data;
            if (wr_psc_b) psc_b <= wr_data;
            if (wr_duty_b) duty_b <= wr_data;
        end
    end

    // Selector registers, four pins each, lowest pin in bits 1:0.
    for (genvar s = 0; s < NSEL; s++) begin : g_sel
        always_ff @(posedge mclk) begin
            if (!run) begin
                pin_selector_reg[s] <= `LPMR_SEL_RESET;
            end else if (wr_valid && ptr_in_sel && sel_idx == 4'(s)) begin
                pin_selector_reg[s] <= wr_data;
            end
        end
    end

    // Two blink generators; a duty write restarts its period.
    lpmr_blink_if wave_a ();
    lpmr_blink_if wave_b ();
    assign wave_a.psc = psc_a;
    assign wave_a.duty = duty_a;
    assign wave_a.restart = wr_duty_a;
    assign wave_b.psc = psc_b;
    assign wave_b.duty = duty_b;
    assign wave_b.restart = wr_duty_b;

    lpmr_blink #(.TICK_DIV(TICK_DIV)) u_blink_a (
        .mclk(mclk),
        .run(run),
        .bi(wave_a.gen)
    );
    lpmr_blink #(.TICK_DIV(TICK_DIV)) u_blink_b (
        .mclk(mclk),
        .run(run),
        .bi(wave_b.gen)
    );

    // Per-pin drive decision; the pin is never driven high.
    logic [PINS-1:0] next_oe;
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        wire [1:0] code = pin_selector_reg[p / 4][2 * (p % 4) +: 2];
        assign next_oe[p] =
            (code == `LPMR_SEL_LOW) ? 1'b1 :
            (code == `LPMR_SEL_RELEASE) ? 1'b0 :
            (code == `LPMR_SEL_WAVE_A) ? wave_a.wave_low :
            wave_b.wave_low;
    end

    // Registered enables keep the pins glitch-free; defaults release all.
    always_ff @(posedge mclk) begin
        if (!run) begin
            driver_pins_oe <= '0;
        end else begin
            driver_pins_oe <= next_oe;
        end
    end
    assign driver_pins_out = '0;

    // Read mux; the level registers always show the synchronised pins.
    lpmr_byte_t next_rd;
    always_comb begin
        next_rd = `LPMR_BYTE_ZERO;
        if (ptr == `LPMR_IDX_LEVEL_LO) next_rd = pin_sync[7:0];
        if (ptr == `LPMR_IDX_LEVEL_HI) next_rd = pin_sync[15:8];
        if (ptr == `LPMR_IDX_PSC_A) next_rd = psc_a;
        if (ptr == `LPMR_IDX_DUTY_A) next_rd = duty_a;
        if (ptr == `LPMR_IDX_PSC_B) next_rd = psc_b;
        if (ptr == `LPMR_IDX_DUTY_B) next_rd = duty_b;
        if (ptr_in_sel) next_rd = pin_selector_reg[sel_idx[1:0]];
    end

    // Read answer one cycle after the request.
    always_ff @(posedge mclk) begin
        if (!run) begin
            rd_data <= `LPMR_BYTE_ZERO;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) rd_data <= next_rd;
        end
    end
endmodule : lpmr_top

`default_nettype wire

//--- testbench/lpmr_top_assertions.sv
// Checker of the pin mode and reset block, bound onto its top module.
// Assumes one clock, mclk, and synchronous resets.
`default_nettype none
module lpmr_top_assertions #(
    parameter int PINS = 16
) (
    // Clock and resets.
    input wire logic mclk,
    input wire logic rstn,
    input wire logic por_n,
    // Byte port.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic wr_valid,
    input wire logic rd_req,
    input wire logic rd_valid,
    // Status and pins.
    input wire logic [3:0] reg_ptr,
    input wire logic auto_increment_flag,
    input wire logic in_reset,
    input wire logic [PINS-1:0] driver_pins_out,
    input wire logic [PINS-1:0] driver_pins_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic step;
    // With auto-increment on, a byte op moves the pointer; a command in the same cycle wins.
    assign step = (wr_valid || rd_req) && !cmd_valid && !in_reset &&
        auto_increment_flag && por_n;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Power-on reset raises in_reset on the next edge; the registers
    // follow one edge later, because they reset from the release flop.
    property p_por; !por_n |=> in_reset ##1
        reg_ptr == 4'h0 && !auto_increment_flag; endproperty
    a_por: assert property (p_por) else $error("por defaults");
    // Release comes two edges after the resets go high.
    property p_rel; $fell(in_reset) |-> $past(por_n) && $past(por_n, 2);
    endproperty
    a_rel: assert property (p_rel) else $error("early release");
    property p_rdv; rd_req && !in_reset && por_n |=> rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("no read answer");
    property p_rdo; rd_valid |-> $past(rd_req); endproperty
    a_rdo: assert property (p_rdo) else $error("stray read");
    property p_cmd; cmd_valid && !in_reset && por_n |=>
        {auto_increment_flag, reg_ptr} == $past(cmd_byte[4:0]); endproperty
    a_cmd: assert property (p_cmd) else $error("command load");
    property p_inc; step && reg_ptr < 4'h9 |=>
        reg_ptr == $past(reg_ptr) + 4'h1; endproperty
    a_inc: assert property (p_inc) else $error("pointer step");
    property p_wrap; step && reg_ptr >= 4'h9 |=> reg_ptr == 4'h0; endproperty
    a_wrap: assert property (p_wrap) else $error("pointer wrap");
    // Open drain: the pins are never driven high.
    property p_out; driver_pins_out == '0; endproperty
    a_out: assert property (p_out) else $error("pin driven high");
    // While the internal reset holds, every pin is released next edge.
    property p_rst_oe; in_reset |=> driver_pins_oe == '0; endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("pin sunk in reset");
endmodule : lpmr_top_assertions
`default_nettype wire

//--- testbench/lpmr_pins_model.sv
// Pull-ups and outside drivers on the open-drain pins.
// Assumes oe high means the block sinks the pin.
`default_nettype none
module lpmr_pins_model #(
    parameter int PINS = 16
) (
    // Block side.
    input wire logic [PINS-1:0] oe,
    // Bench side: pins held low by an outside driver.
    input wire logic [PINS-1:0] ext_low,
    output logic [PINS-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin rises to the pull-up unless held low outside.
    assign level = ~(oe | ext_low);
endmodule : lpmr_pins_model
`default_nettype wire

//--- testbench/tb_lpmr_top.sv
// Bench of the pin mode and reset block, one task per scenario.
// Assumes the design, pins model and checker compile before it.
`default_nettype none
module tb_lpmr_top import lpmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic por_n = 1'b1;
    logic cmd_valid = 1'b0;
    logic wr_valid = 1'b0;
    logic rd_req = 1'b0;
    lpmr_byte_t cmd_byte = 8'h00;
    lpmr_byte_t wr_data = 8'h00;
    lpmr_byte_t rd_data;
    logic rd_valid;
    lpmr_ptr_t reg_ptr;
    logic ai;
    logic in_reset;
    logic [15:0] pins_in;
    logic [15:0] oe;
    logic [15:0] ext_low = 16'h0000;
    int failures = 0;
    int n_tests = 0;

    // Half period of the 4 ns clock.
    always #2 mclk = ~mclk;

    // TICK_DIV of 1 keeps blink steps short.
    lpmr_top #(.PINS(16), .TICK_DIV(1)) dut (
        .mclk(mclk), .rstn(rstn), .por_n(por_n),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .reg_ptr(reg_ptr),
        .auto_increment_flag(ai), .in_reset(in_reset),
        .driver_pins_in(pins_in), .driver_pins_out(),
        .driver_pins_oe(oe));
    lpmr_pins_model #(.PINS(16)) pins (.oe(oe), .ext_low(ext_low),
        .level(pins_in));

    task automatic complete_run;
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk

    // Sets all strobes each call, so no signal is assigned twice a step.
    // The bytes stand for what the host sends after the address byte c0h.
    task automatic op(input logic [2:0] k, input lpmr_byte_t b);
        {cmd_valid, wr_valid, rd_req} = k;
        cmd_byte = b;
        wr_data = b;
        @(negedge mclk);
    endtask : op

    // The answer stands for one cycle only, so it is judged right after
    // the request edge and before the strobe drops.
    task automatic rd(input lpmr_byte_t e);
        op(3'b001, 8'h00);
        chk("rd_valid", 16'h1, {15'h0, rd_valid});
        chk("rd_data", {8'h00, e}, {8'h00, rd_data});
        op(3'b000, 8'h00);
    endtask : rd

    task automatic wait_ready;
        for (int i = 0; i < 10 && in_reset !== 1'b0; i++)
            @(negedge mclk);
        if (in_reset !== 1'b0) begin
            failures++;
            complete_run();
        end
    endtask : wait_ready

    task automatic t_defaults;
        lpmr_byte_t x[8] = '{8'hff, 8'h80, 8'hff, 8'h80, 8'h55, 8'h55,
            8'h55, 8'h55};
        op(3'b100, 8'h12);
        foreach (x[i]) rd(x[i]);
        chk("reg_ptr", 16'h0, {12'h0, reg_ptr});
        chk("oe", 16'h0, oe);
    endtask : t_defaults

    task automatic t_program;
        lpmr_byte_t v[8] = '{8'h2b, 8'h00, 8'h0a, 8'hff, 8'h00, 8'haa,
            8'hff, 8'h55};
        op(3'b100, 8'h12);
        foreach (v[i]) op(3'b010, v[i]);
        repeat (2) op(3'b000, 8'h00);
        chk("oe", 16'h0f0f, oe);
        chk("reg_ptr", 16'h0, {12'h0, reg_ptr});
        op(3'b100, 8'h12);
        foreach (v[i]) rd(v[i]);
        // A duty write restarts the step counter, so step 0 is low.
        op(3'b100, 8'h05);
        op(3'b010, 8'h01);
        repeat (3) op(3'b000, 8'h00);
        chk("wave_b low", 16'h1, {15'h0, oe[8]});
        repeat (16) op(3'b000, 8'h00);
        chk("wave_b high", 16'h0, {15'h0, oe[8]});
    endtask : t_program

    task automatic t_levels;
        ext_low = 16'h5050;
        op(3'b100, 8'h10);
        repeat (2) op(3'b000, 8'h00);
        rd(8'ha0);
        rd(8'haf);
        op(3'b100, 8'h00);
        op(3'b010, 8'h33);
        rd(8'ha0);
        op(3'b100, 8'h0a);
        rd(8'h00);
    endtask : t_levels

    task automatic t_reset(input logic por);
        if (por)
            por_n = 1'b0;
        else
            rstn = 1'b0;
        op(3'b100, 8'h16);
        repeat (4) begin
            op(3'b000, 8'h00);
            chk("in_reset", 16'h1, {15'h0, in_reset});
        end
        chk("oe", 16'h0, oe);
        rstn = 1'b1;
        por_n = 1'b1;
        op(3'b000, 8'h00);
        chk("in_reset", 16'h1, {15'h0, in_reset});
        wait_ready();
        op(3'b100, 8'h16);
        rd(8'h55);
        chk("reg_ptr", 16'h7, {12'h0, reg_ptr});
    endtask : t_reset

    initial begin
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        wait_ready();
        t_defaults();
        t_program();
        t_levels();
        t_reset(1'b0);
        t_reset(1'b1);
        complete_run();
    end
endmodule : tb_lpmr_top

bind lpmr_top lpmr_top_assertions #(.PINS(PINS)) u_chk (
    .mclk(mclk), .rstn(rstn), .por_n(por_n), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .wr_valid(wr_valid), .rd_req(rd_req),
    .rd_valid(rd_valid), .reg_ptr(reg_ptr), .in_reset(in_reset),
    .auto_increment_flag(auto_increment_flag),
    .driver_pins_out(driver_pins_out), .driver_pins_oe(driver_pins_oe));
`default_nettype wire
